// [core/port_de_device.sv]
// port d and port e with direction control and parallel slave mode
// assumes processor register port on SYS_CLK; pins arrive asynchronously through the carrier
`timescale 1ns/1ps
module port_de_device (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [7:0] RDATA,
	output logic SLAVE_PORT_DONE,
	port_de_if.device pins
);
	import port_de_pkg::*;

	// pin synchronisers, two flops each
	logic [7:0] d_meta, d_sync; // port d pins
	logic [2:0] e_meta, e_sync; // port e pins

	// processor visible state
	logic [7:0] out_latch, next_out_latch; // port d output latch
	logic [7:0] in_latch, next_in_latch; // slave port input latch
	logic [2:0] e_out, next_e_out; // port e output latch
	logic [7:0] port_d_direction, next_port_d_direction; // one means input
	logic [2:0] e_dir, next_e_dir; // port e direction, one means input
	logic slave_port_select, next_slave_port_select; // parallel slave mode
	logic input_full_flag, next_input_full_flag; // external word waiting
	logic output_full_flag, next_output_full_flag; // written word not yet read out
	logic input_overrun_flag, next_input_overrun_flag; // write over unread word
	logic [7:0] analog_pin_config, next_analog_pin_config; // analog pin control
	logic [7:0] rdata, next_rdata; // read answer, one cycle late
	// slave port strobe tracking
	logic wr_seen, next_wr_seen; // external write under way
	logic rd_seen, next_rd_seen; // external read under way
	logic wr_pend, next_wr_pend; // write ended, flag setting one cycle on
	logic done, next_done; // transfer complete pulse

	// decoded strobes from synchronised pins
	logic ext_wr_act; // select and write low
	logic ext_rd_act; // select and read low
	logic e_analog; // port e pins in analog use
	logic [2:0] e_read; // port e data as read

	// only the second flop of each synchroniser is read
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			d_meta <= 8'hff;
			d_sync <= 8'hff;
			e_meta <= 3'h7;
			e_sync <= 3'h7;
		end else begin
			d_meta <= pins.d_line;
			d_sync <= d_meta;
			e_meta <= pins.e_line;
			e_sync <= e_meta;
		end
	end

	// strobes count only in slave mode
	assign ext_wr_act = slave_port_select && !e_sync[2] && !e_sync[1];
	assign ext_rd_act = slave_port_select && !e_sync[2] && !e_sync[0];
	// pins are digital only with config bit 2 set; reset value keeps them analog
	assign e_analog = !analog_pin_config[ANALOG_CFG_BIT2];
	assign e_read = e_analog ? 3'h0 : e_sync;

	// next values of all processor and slave port state
	always_comb begin
		next_out_latch = out_latch;
		next_in_latch = in_latch;
		next_e_out = e_out;
		next_port_d_direction = port_d_direction;
		next_e_dir = e_dir;
		next_slave_port_select = slave_port_select;
		next_input_full_flag = input_full_flag;
		next_output_full_flag = output_full_flag;
		next_input_overrun_flag = input_overrun_flag;
		next_analog_pin_config = analog_pin_config;
		next_rdata = 8'h00;
		next_wr_seen = ext_wr_act;
		next_rd_seen = ext_rd_act;
		next_wr_pend = 1'b0;
		next_done = 1'b0;

		// processor writes
		if (WR_STB) begin
			case (ADDR)
				PORT_D_DATA_OFS: begin
					next_out_latch = WDATA;
					if (slave_port_select) begin
						next_output_full_flag = 1'b1;
					end
				end
				PORT_E_DATA_OFS: begin
					next_e_out = WDATA[2:0];
				end
				PORT_D_DIRECTION_OFS: begin
					next_port_d_direction = WDATA;
				end
				PORT_E_DIRECTION_OFS: begin
					// full flags are read-only; overrun only by software
					next_input_overrun_flag = WDATA[OVERRUN_BIT];
					next_slave_port_select = WDATA[SLAVE_SELECT_BIT];
					next_e_dir = WDATA[2:0];
				end
				ANALOG_PIN_CONFIG_OFS: begin
					next_analog_pin_config = WDATA;
				end
				default: begin
					// unmapped write ignored
				end
			endcase
		end

		// processor reads, answered next cycle
		if (RD_STB) begin
			case (ADDR)
				PORT_D_DATA_OFS: begin
					if (slave_port_select) begin
						next_rdata = in_latch;
						next_input_full_flag = 1'b0;
					end else begin
						next_rdata = d_sync;
					end
				end
				PORT_E_DATA_OFS: begin
					next_rdata = {5'h00, e_read};
				end
				PORT_D_DIRECTION_OFS: begin
					next_rdata = port_d_direction;
				end
				PORT_E_DIRECTION_OFS: begin
					// bit 3 unimplemented
					next_rdata = {input_full_flag, output_full_flag, input_overrun_flag,
						slave_port_select, 1'b0, e_dir};
				end
				ANALOG_PIN_CONFIG_OFS: begin
					next_rdata = analog_pin_config;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end

		// pin data follow the bus while the write is active
		if (ext_wr_act) begin
			next_in_latch = d_sync;
		end

		// write end: the latch already holds the last data, flags follow a cycle on
		if (wr_seen && !ext_wr_act) begin
			next_wr_pend = 1'b1;
		end
		// setting wins over a processor read or overrun write in the same cycle
		if (wr_pend) begin
			if (input_full_flag) begin
				next_input_overrun_flag = 1'b1;
			end
			next_input_full_flag = 1'b1;
			next_done = 1'b1;
		end

		// external read clears output-full and keeps it clear; clear beats a write
		if (ext_rd_act) begin
			next_output_full_flag = 1'b0;
		end
		if (rd_seen && !ext_rd_act) begin
			next_done = 1'b1;
		end

		// general purpose mode holds full flags clear, overrun kept
		if (!slave_port_select) begin
			next_input_full_flag = 1'b0;
			next_output_full_flag = 1'b0;
		end
	end

	// register everything; every reset makes port d inputs
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			out_latch <= 8'h00;
			in_latch <= 8'h00;
			e_out <= 3'h0;
			port_d_direction <= PORT_D_DIRECTION_RST;
			e_dir <= PORT_E_DIR_RST;
			slave_port_select <= 1'b0;
			input_full_flag <= 1'b0;
			output_full_flag <= 1'b0;
			input_overrun_flag <= 1'b0;
			analog_pin_config <= ANALOG_PIN_CONFIG_RST;
			rdata <= 8'h00;
			wr_seen <= 1'b0;
			rd_seen <= 1'b0;
			wr_pend <= 1'b0;
			done <= 1'b0;
		end else begin
			out_latch <= next_out_latch;
			in_latch <= next_in_latch;
			e_out <= next_e_out;
			port_d_direction <= next_port_d_direction;
			e_dir <= next_e_dir;
			slave_port_select <= next_slave_port_select;
			input_full_flag <= next_input_full_flag;
			output_full_flag <= next_output_full_flag;
			input_overrun_flag <= next_input_overrun_flag;
			analog_pin_config <= next_analog_pin_config;
			rdata <= next_rdata;
			wr_seen <= next_wr_seen;
			rd_seen <= next_rd_seen;
			wr_pend <= next_wr_pend;
			done <= next_done;
		end
	end

	// port d: direction bits in gpio mode, external read strobe in slave mode
	// a late processor write shows at once since the latch drives directly
	assign pins.dev_d_out = out_latch;
	assign pins.dev_d_oe = slave_port_select ? {8{ext_rd_act}} : ~port_d_direction;
	// port e keeps its direction bits in every mode; software must set them inputs
	assign pins.dev_e_out = e_out;
	assign pins.dev_e_oe = ~e_dir;
	assign RDATA = rdata;
	assign SLAVE_PORT_DONE = done;
endmodule

// [core/port_de_pkg.sv]
// constants shared by the port d/e device end, the bus master end and the testbench
// assumes one system clock at 100 mhz and one asynchronous active-low reset
// How it works
// - port d pins each have own direction
// - direction e bit 4 selects slave port
// - port e has three directed pins
// - slave mode: port e is read/write/select
// - software sets e pins digital inputs first
// - analog port e pins read zero
// - e direction bits act even when analog
// - after reset port e pins are analog
// - output-full while written word unread externally
// - select and read low drive output latch
// - select and write low latch port d
// - master drives select low to choose device
// - every reset makes port d inputs
// - write end latches, then sets input-full
// - external read clears output-full and holds it
// - processor read of data clears input-full
// - outside slave mode full flags held clear
package port_de_pkg;
	// register offsets on the processor port
	localparam logic [7:0] PORT_D_DATA_OFS = 8'h08;
	localparam logic [7:0] PORT_E_DATA_OFS = 8'h09;
	localparam logic [7:0] PORT_D_DIRECTION_OFS = 8'h88;
	localparam logic [7:0] PORT_E_DIRECTION_OFS = 8'h89;
	localparam logic [7:0] ANALOG_PIN_CONFIG_OFS = 8'h9f;
	// field positions in the port e direction and slave control register and in analog pin config
	localparam int INPUT_FULL_BIT = 7;
	localparam int OUTPUT_FULL_BIT = 6;
	localparam int OVERRUN_BIT = 5;
	localparam int SLAVE_SELECT_BIT = 4;
	localparam int ANALOG_CFG_BIT2 = 2;
	// values after reset
	localparam logic [7:0] PORT_D_DIRECTION_RST = 8'hff;
	localparam logic [2:0] PORT_E_DIR_RST = 3'h7;
	localparam logic [7:0] ANALOG_PIN_CONFIG_RST = 8'h00;
	// master strobe timing, in ns and derived cycles
	localparam int CLK_NS = 10;
	localparam int STROBE_NS = 80;
	localparam int GAP_NS = 40;
	localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;
	// least strobe and gap the device can see through its synchronisers
	localparam int MIN_STROBE_CYCLES = 6;
	localparam int MIN_GAP_CYCLES = 4;
	// master states
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_WRITE = 2'b01,
		M_READ = 2'b10,
		M_GAP = 2'b11
	} master_state_t;
endpackage

// [core/port_de_if.sv]
// pin carrier between the port d/e device and the external bus master
// assumes both ends share one clock; a released line floats high through a pull-up
`timescale 1ns/1ps
interface port_de_if;
	logic [7:0] dev_d_out; // device drive value on port d
	logic [7:0] dev_d_oe; // device drives port d bit
	logic [7:0] host_d_out; // master drive value on port d
	logic [7:0] host_d_oe; // master drives port d bit
	logic [7:0] d_line; // resolved port d level
	logic [2:0] dev_e_out; // device drive value on port e
	logic [2:0] dev_e_oe; // device drives port e bit
	logic [2:0] host_e_out; // master strobes: 0 read_n, 1 write_n, 2 select_n
	logic [2:0] host_e_oe; // master drives port e bit
	logic [2:0] e_line; // resolved port e level
	// device wins a clash; undriven reads as one
	assign d_line = (dev_d_oe & dev_d_out) | (~dev_d_oe & host_d_oe & host_d_out)
		| (~dev_d_oe & ~host_d_oe);
	assign e_line = (dev_e_oe & dev_e_out) | (~dev_e_oe & host_e_oe & host_e_out)
		| (~dev_e_oe & ~host_e_oe);
	modport device (output dev_d_out, output dev_d_oe, output dev_e_out, output dev_e_oe,
		input d_line, input e_line);
	modport host (output host_d_out, output host_d_oe, output host_e_out,
		output host_e_oe, input d_line, input e_line);
endinterface

// [core/port_de_master.sv]
// external 8-bit bus master end: drives select, read and write strobes on port e
// assumes the shared system clock; one transfer at a time, requests taken when not busy
`timescale 1ns/1ps
module port_de_master #(
	parameter int STROBE_LEN = port_de_pkg::STROBE_CYCLES,
	parameter int GAP_LEN = port_de_pkg::GAP_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic WR_REQ,
	input wire logic RD_REQ,
	input wire logic [7:0] WDATA,
	output logic BUSY,
	output logic [7:0] RDATA,
	output logic RDATA_VALID,
	port_de_if.host pins
);
	import port_de_pkg::*;

	// refuse strobes too short for the device synchronisers
	if (STROBE_LEN < MIN_STROBE_CYCLES || GAP_LEN < MIN_GAP_CYCLES || STROBE_LEN > 255
		|| GAP_LEN > 255) begin : g_check
		$error("port_de_master: strobe or gap length out of range");
	end

	master_state_t state, next_state; // transfer sequencer
	logic [7:0] cnt, next_cnt; // cycles left in phase
	logic [7:0] dout, next_dout; // data held on port d
	logic [7:0] d_meta, d_sync; // read data synchroniser
	logic [7:0] rdata, next_rdata; // captured read word
	logic rvalid, next_rvalid; // one-cycle read done

	// sequencer next values
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_dout = dout;
		next_rdata = rdata;
		next_rvalid = 1'b0;
		case (state)
			M_IDLE: begin
				// write wins when both asked at once
				if (WR_REQ) begin
					next_state = M_WRITE;
					next_dout = WDATA;
					next_cnt = 8'(STROBE_LEN - 1);
				end else if (RD_REQ) begin
					next_state = M_READ;
					next_cnt = 8'(STROBE_LEN - 1);
				end
			end
			M_WRITE: begin
				if (cnt == 8'h00) begin
					next_state = M_GAP;
					next_cnt = 8'(GAP_LEN - 1);
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			M_READ: begin
				// sample on the last strobe cycle, device data long settled
				if (cnt == 8'h00) begin
					next_state = M_GAP;
					next_cnt = 8'(GAP_LEN - 1);
					next_rdata = d_sync;
					next_rvalid = 1'b1;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			M_GAP: begin
				if (cnt == 8'h00) begin
					next_state = M_IDLE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			default: begin
				next_state = M_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= M_IDLE;
			cnt <= 8'h00;
			dout <= 8'h00;
			d_meta <= 8'h00;
			d_sync <= 8'h00;
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			dout <= next_dout;
			d_meta <= pins.d_line;
			d_sync <= d_meta;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// select low only during a strobe
	assign pins.host_e_out = {~(state == M_WRITE || state == M_READ), ~(state == M_WRITE),
		~(state == M_READ)};
	assign pins.host_e_oe = 3'h7; // strobes always driven, idle high
	// data kept through all but the last gap cycle so the device latch sees it settle
	assign pins.host_d_oe = {8{state == M_WRITE || (state == M_GAP && cnt != 8'h00)}};
	assign pins.host_d_out = dout;
	assign BUSY = (state != M_IDLE);
	assign RDATA = rdata;
	assign RDATA_VALID = rvalid;
endmodule

// [verif/port_de_monitor.sv]
// checker on the port d/e pin carrier between the two ends
// assumes one clock domain; the master reads only while slave mode is on
`timescale 1ns/1ps
module port_de_monitor (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [7:0] dev_d_oe,
	input wire logic [7:0] host_d_out,
	input wire logic [7:0] host_d_oe,
	input wire logic [2:0] host_e_out,
	input wire logic [2:0] host_e_oe
);
	// one domain, so one default clock and reset
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!ARST_N);
	a_strobes_driven: assert property (host_e_oe == 3'h7)
		else $error("strobe pins released by master");
	a_write_selects: assert property (!host_e_out[1] |-> !host_e_out[2])
		else $error("write strobe without select");
	a_read_selects: assert property (!host_e_out[0] |-> !host_e_out[2])
		else $error("read strobe without select");
	a_write_drives_data: assert property (!host_e_out[1] |-> host_d_oe == 8'hff)
		else $error("write strobe without data drive");
	a_write_data_held: assert property (!host_e_out[1] && !$past(host_e_out[1])
		|-> $stable(host_d_out))
		else $error("write data moved in strobe");
	a_write_len: assert property ($fell(host_e_out[1])
		|-> (!host_e_out[1])[*8] ##1 host_e_out[1])
		else $error("write strobe length wrong");
	a_read_len: assert property ($fell(host_e_out[0])
		|-> (!host_e_out[0])[*8] ##1 host_e_out[0])
		else $error("read strobe length wrong");
	a_read_drives: assert property ((!host_e_out[0])[*5] |-> dev_d_oe == 8'hff)
		else $error("device not driving in read");
	a_read_release: assert property ($rose(host_e_out[0])
		|-> ##[1:6] (dev_d_oe == 8'h00))
		else $error("device kept driving after read");
	a_gap_kept: assert property ($rose(host_e_out[2]) |-> host_e_out[2][*4])
		else $error("select gap too short");
endmodule

// [verif/testbench.sv]
// self-checking bench: register port tasks and master requests against both ends
// assumes the master strobe defaults; expected values come from the register map
`timescale 1ns/1ps
module testbench;
	import port_de_pkg::*;
	logic sys_clk = 1'b0; // 100 mhz system clock
	logic arst_n = 1'b0; // async reset, active low
	logic [7:0] addr = 8'h00, wdata = 8'h00, m_wdata = 8'h00;
	logic wr_stb = 1'b0, rd_stb = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
	logic [7:0] rdata, m_rdata;
	logic done, busy, m_valid;
	int num_errors = 0, n_tests = 0, cyc = 0, done_cnt = 0;
	port_de_if u_port_de_if ();
	port_de_device u_port_de_device (.SYS_CLK(sys_clk), .ARST_N(arst_n), .ADDR(addr),
		.WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
		.SLAVE_PORT_DONE(done), .pins(u_port_de_if));
	port_de_master u_port_de_master (.SYS_CLK(sys_clk), .ARST_N(arst_n), .WR_REQ(wr_req),
		.RD_REQ(rd_req), .WDATA(m_wdata), .BUSY(busy), .RDATA(m_rdata),
		.RDATA_VALID(m_valid), .pins(u_port_de_if));
	port_de_monitor u_port_de_monitor (.SYS_CLK(sys_clk), .ARST_N(arst_n),
		.dev_d_oe(u_port_de_if.dev_d_oe), .host_d_out(u_port_de_if.host_d_out),
		.host_d_oe(u_port_de_if.host_d_oe), .host_e_out(u_port_de_if.host_e_out),
		.host_e_oe(u_port_de_if.host_e_oe));
	// clock and a short reset at the start
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// cycle ceiling cuts a hang short; done pulses counted for the event check
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (done === 1'b1) done_cnt <= done_cnt + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask
	// one-cycle register read; data stand only in the next cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// wait for the master to go idle, then let the device finish
	task automatic idle_wait();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			@(posedge sys_clk);
			#1 n++;
		end
		if (busy !== 1'b0) chk(8'h01, 8'h00);
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic mwr(input logic [7:0] d);
		@(posedge sys_clk);
		wr_req <= 1'b1;
		m_wdata <= d;
		@(posedge sys_clk);
		wr_req <= 1'b0;
		#1 idle_wait();
	endtask
	task automatic mrd(input logic [7:0] e);
		int n;
		n = 0;
		@(posedge sys_clk);
		rd_req <= 1'b1;
		@(posedge sys_clk);
		rd_req <= 1'b0;
		#1;
		while (m_valid !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk(m_rdata, e);
		idle_wait();
	endtask
	task automatic t_reset();
		rd(PORT_D_DIRECTION_OFS, 8'hff);
		rd(PORT_E_DIRECTION_OFS, 8'h07);
		rd(ANALOG_PIN_CONFIG_OFS, 8'h00);
		rd(PORT_E_DATA_OFS, 8'h00);
		rd(8'h55, 8'h00);
		wr(8'h55, 8'hff);
		wr(PORT_E_DIRECTION_OFS, 8'h0f);
		rd(PORT_E_DIRECTION_OFS, 8'h07);
		$display("test reset done");
	endtask
	task automatic t_gpio();
		wr(PORT_D_DIRECTION_OFS, 8'h0f);
		wr(PORT_D_DATA_OFS, 8'ha5);
		repeat (3) @(posedge sys_clk);
		chk(u_port_de_if.dev_d_oe, 8'hf0);
		rd(PORT_D_DATA_OFS, 8'haf);
		wr(ANALOG_PIN_CONFIG_OFS, 8'h04);
		wr(PORT_E_DATA_OFS, 8'h00);
		wr(PORT_E_DIRECTION_OFS, 8'h06);
		repeat (3) @(posedge sys_clk);
		rd(PORT_E_DATA_OFS, 8'h06);
		wr(ANALOG_PIN_CONFIG_OFS, 8'h00);
		rd(PORT_E_DATA_OFS, 8'h00);
		chk({5'h00, u_port_de_if.dev_e_oe}, 8'h01);
		$display("test gpio done");
	endtask
	task automatic t_slave();
		wr(ANALOG_PIN_CONFIG_OFS, 8'h04);
		wr(PORT_E_DIRECTION_OFS, 8'h17);
		mwr(8'h3c);
		rd(PORT_E_DIRECTION_OFS, 8'h97);
		rd(PORT_D_DATA_OFS, 8'h3c);
		rd(PORT_E_DIRECTION_OFS, 8'h17);
		mwr(8'h11);
		mwr(8'h22);
		rd(PORT_E_DIRECTION_OFS, 8'hb7);
		wr(PORT_E_DIRECTION_OFS, 8'h27);
		rd(PORT_E_DIRECTION_OFS, 8'h27);
		mwr(8'h77);
		rd(PORT_E_DIRECTION_OFS, 8'h27);
		wr(PORT_E_DIRECTION_OFS, 8'h17);
		rd(PORT_E_DIRECTION_OFS, 8'h17);
		wr(PORT_D_DATA_OFS, 8'hc3);
		rd(PORT_E_DIRECTION_OFS, 8'h57);
		mrd(8'hc3);
		rd(PORT_E_DIRECTION_OFS, 8'h17);
		chk(done_cnt[7:0], 8'h04);
		$display("test slave done");
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_gpio();
		t_slave();
		tally_and_finish();
	end
endmodule
